// ==== common/redriver_cfg_pkg.sv ====
// Purpose: Shared constants for the redriver configuration register bank.
// Assumes: Two-wire bus target sampled by a single 250 MHz system clock.
// Notes:   Offsets are register indexes carried in the bus index byte.

`default_nettype none

package redriver_cfg_pkg;

  // Register indexes
  localparam logic [7:0] IDX_GENERAL     = 8'h00;
  localparam logic [7:0] IDX_LANE_ENABLE = 8'h01;
  localparam logic [7:0] IDX_LANE0_CTRL  = 8'h02;
  localparam logic [7:0] IDX_LANE0_STAGE = 8'h03;

  // Reset values
  localparam logic [7:0] RST_GENERAL     = 8'h00;
  localparam logic [3:0] RST_LANE_ENABLE = 4'h0;
  localparam logic [7:0] RST_LANE0_CTRL  = 8'h00;
  localparam logic [2:0] RST_LANE0_STAGE = 3'h0;

  // General register fields
  localparam int GEN_CTRL_SRC  = 7;
  localparam int GEN_POWER_OFF = 6;
  localparam int GEN_TRACK_01  = 5;
  localparam int GEN_TRACK_23  = 4;
  localparam int GEN_TRACK_ALL = 3;
  localparam int GEN_EQ_PROF   = 2;

  // Lane control fields
  localparam int CTL_EQ_HI     = 6;
  localparam int CTL_EQ_LO     = 4;
  localparam int CTL_OUT_GAIN  = 3;
  localparam int CTL_IN_GAIN   = 2;
  localparam int CTL_RX_HI     = 1;
  localparam int CTL_RX_LO     = 0;

  // Lane stage enable fields
  localparam int STG_HF_BOOST  = 2;
  localparam int STG_EQ_OFF    = 1;
  localparam int STG_DRV_OFF   = 0;

  // Implemented widths
  localparam int LANE_EN_W     = 4;
  localparam int STAGE_W       = 3;

  // Target address: upper four bits fixed
  localparam logic [3:0] TARGET_ADDR_HI = 4'h0;

  // Bits per byte on the bus
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_INDEX,
    ST_INDEX_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } bus_state_t;

endpackage

`default_nettype wire

// ==== logic/cfg_sync2.sv ====
// Purpose: Two flip-flop synchroniser for pins entering the system clock.
// Assumes: Inputs are levels from outside the clock domain.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/1ps
`default_nettype none

module cfg_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta   <= INIT;
      o_sync <= INIT;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== logic/lane_track_select.sv ====
// Purpose: Works out which lane's settings each lane applies.
// Assumes: Lane 1 settings arrive from the lane 1 register copy.
// Notes:   Global tracking is checked first so pairwise bits cannot leak.

`timescale 1ns/1ps
`default_nettype none

module lane_track_select (
  // Tracking controls, 0 means track
  input  wire logic       i_track_01_n,
  input  wire logic       i_track_23_n,
  input  wire logic       i_track_all_n,
  // Lane 0 own and lane 1 settings
  input  wire logic [7:0] i_lane0_ctrl,
  input  wire logic [2:0] i_lane0_stage,
  input  wire logic [7:0] i_lane1_ctrl,
  input  wire logic [2:0] i_lane1_stage,
  // Selections
  output logic      [3:0] o_follow_lane1,
  output logic            o_lane3_follow_lane2,
  output logic      [7:0] o_eff_ctrl,
  output logic      [2:0] o_eff_stage
);

  wire lane0_tracks = ~i_track_all_n | ~i_track_01_n;

  assign o_follow_lane1       = {~i_track_all_n, ~i_track_all_n, 1'b0, lane0_tracks};
  assign o_lane3_follow_lane2 = i_track_all_n & ~i_track_23_n;
  assign o_eff_ctrl           = lane0_tracks ? i_lane1_ctrl : i_lane0_ctrl;
  assign o_eff_stage          = lane0_tracks ? i_lane1_stage : i_lane0_stage;

endmodule

`default_nettype wire

// ==== logic/redriver_cfg_regs.sv ====
// Purpose: Configuration register bank with its two-wire bus target.
// Assumes: Bus pins are oversampled by i_clk; bus clock far below i_clk/8.
// Notes:   Sequential index increments on both writes and reads.

`timescale 1ns/1ps
`default_nettype none

module redriver_cfg_regs (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Two-wire bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Straps
  input  wire logic [2:0] i_addr_pins,
  input  wire logic       i_ctrl_mode_pin,
  // Lane 1 settings from its register copy
  input  wire logic [7:0] i_lane1_ctrl,
  input  wire logic [2:0] i_lane1_stage,
  // Global controls
  output logic            o_pin_control_active,
  output logic            o_power_off_request,
  output logic            o_equalizer_profile_select,
  output logic      [3:0] o_lane_disable,
  output logic      [3:0] o_follow_lane1,
  output logic            o_lane3_follow_lane2,
  // Effective lane 0 settings
  output logic      [2:0] o_eq_strength_code,
  output logic            o_output_dc_gain_6db,
  output logic            o_input_dc_attenuation,
  output logic      [1:0] o_rx_gain_code,
  output logic            o_driver_hf_boost,
  output logic            o_eq_stage_off,
  output logic            o_driver_stage_off_lane0
);

  // Synchronised pins
  logic [5:0] pins_s;
  logic       scl_q;
  logic       sda_q;

  cfg_sync2 #(
    .WIDTH (6),
    .INIT  (6'h3b)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_scl, i_sda, i_ctrl_mode_pin, i_addr_pins}),
    .o_sync  (pins_s)
  );

  wire       scl_s      = pins_s[5];
  wire       sda_s      = pins_s[4];
  wire       mode_pin_s = pins_s[3];
  wire [2:0] addr_s     = pins_s[2:0];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  // Protocol state
  redriver_cfg_pkg::bus_state_t state;
  redriver_cfg_pkg::bus_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] index;
  logic       rd_dir;

  // Registers
  logic [7:0] general;
  logic [3:0] lane_enable;
  logic [7:0] lane0_ctrl;
  logic [2:0] lane0_stage;

  wire byte_done  = (bit_cnt == redriver_cfg_pkg::BYTE_BITS);
  wire addr_match = (shreg[7:1] == {redriver_cfg_pkg::TARGET_ADDR_HI, addr_s});
  wire rx_state   = (state == redriver_cfg_pkg::ST_ADDR) ||
                    (state == redriver_cfg_pkg::ST_INDEX) ||
                    (state == redriver_cfg_pkg::ST_WDATA);
  wire data_take  = (state == redriver_cfg_pkg::ST_WDATA) && scl_fall && byte_done;

  // Write strobes
  wire wr_general = data_take && (index == redriver_cfg_pkg::IDX_GENERAL);
  wire wr_lane_en = data_take && (index == redriver_cfg_pkg::IDX_LANE_ENABLE);
  wire wr_ctrl    = data_take && (index == redriver_cfg_pkg::IDX_LANE0_CTRL);
  wire wr_stage   = data_take && (index == redriver_cfg_pkg::IDX_LANE0_STAGE);

  // Read selection, unmapped indexes read zero
  wire [7:0] rd_data =
    (index == redriver_cfg_pkg::IDX_GENERAL)     ? general :
    (index == redriver_cfg_pkg::IDX_LANE_ENABLE) ? {4'h0, lane_enable} :
    (index == redriver_cfg_pkg::IDX_LANE0_CTRL)  ? lane0_ctrl :
    (index == redriver_cfg_pkg::IDX_LANE0_STAGE) ? {5'h00, lane0_stage} :
    8'h00;
  wire [7:0] index_inc = index + 8'h01;

  // Next state: start wins over everything, stop returns to idle
  always_comb
  begin
    next_state = state;
    if (bus_start)
      next_state = redriver_cfg_pkg::ST_ADDR;
    else if (bus_stop)
      next_state = redriver_cfg_pkg::ST_IDLE;
    else if (scl_fall)
    begin
      unique case (state)
        redriver_cfg_pkg::ST_IDLE:      next_state = state;
        redriver_cfg_pkg::ST_ADDR:
          if (byte_done)
            next_state = addr_match ? redriver_cfg_pkg::ST_ADDR_ACK
                                    : redriver_cfg_pkg::ST_IDLE;
        redriver_cfg_pkg::ST_ADDR_ACK:
          next_state = rd_dir ? redriver_cfg_pkg::ST_RDATA : redriver_cfg_pkg::ST_INDEX;
        redriver_cfg_pkg::ST_INDEX:
          if (byte_done)
            next_state = redriver_cfg_pkg::ST_INDEX_ACK;
        redriver_cfg_pkg::ST_INDEX_ACK: next_state = redriver_cfg_pkg::ST_WDATA;
        redriver_cfg_pkg::ST_WDATA:
          if (byte_done)
            next_state = redriver_cfg_pkg::ST_WDATA_ACK;
        redriver_cfg_pkg::ST_WDATA_ACK: next_state = redriver_cfg_pkg::ST_WDATA;
        redriver_cfg_pkg::ST_RDATA:
          if (byte_done)
            next_state = redriver_cfg_pkg::ST_RDATA_ACK;
        redriver_cfg_pkg::ST_RDATA_ACK: next_state = redriver_cfg_pkg::ST_RDATA;
        default:                        next_state = redriver_cfg_pkg::ST_IDLE;
      endcase
    end
    else if (scl_rise && (state == redriver_cfg_pkg::ST_RDATA_ACK) && sda_s)
      next_state = redriver_cfg_pkg::ST_IDLE; // Master not-acknowledge ends the read
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state <= redriver_cfg_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Bit counter and receive shifter
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
    end
    else if (bus_start || (scl_fall && next_state != state))
      bit_cnt <= 4'h0;
    else if (scl_rise && (rx_state || state == redriver_cfg_pkg::ST_RDATA))
    begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg   <= {shreg[6:0], sda_s};
    end
  end

  // Direction, index and transmit shifter
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_dir <= 1'b0;
      index  <= 8'h00;
      tx     <= 8'h00;
    end
    else if (scl_fall)
    begin
      if (state == redriver_cfg_pkg::ST_ADDR && byte_done)
        rd_dir <= shreg[0];
      if (state == redriver_cfg_pkg::ST_INDEX && byte_done)
        index <= shreg;
      if (state == redriver_cfg_pkg::ST_WDATA_ACK)
        index <= index_inc;
      if (state == redriver_cfg_pkg::ST_ADDR_ACK)
        tx <= rd_data;
      else if (state == redriver_cfg_pkg::ST_RDATA_ACK)
      begin
        index <= index_inc;
        tx    <= (index_inc == redriver_cfg_pkg::IDX_GENERAL)     ? general :
                 (index_inc == redriver_cfg_pkg::IDX_LANE_ENABLE) ? {4'h0, lane_enable} :
                 (index_inc == redriver_cfg_pkg::IDX_LANE0_CTRL)  ? lane0_ctrl :
                 (index_inc == redriver_cfg_pkg::IDX_LANE0_STAGE) ? {5'h00, lane0_stage} :
                 8'h00;
      end
      else if (state == redriver_cfg_pkg::ST_RDATA && bit_cnt != 4'h0)
        tx <= {tx[6:0], 1'b0};
    end
  end

  // Open-drain data: pull low for acknowledge or a zero data bit
  wire ack_state = (state == redriver_cfg_pkg::ST_ADDR_ACK) ||
                   (state == redriver_cfg_pkg::ST_INDEX_ACK) ||
                   (state == redriver_cfg_pkg::ST_WDATA_ACK);
  // Last bit is held until the clock falls; letting go while it is high reads as a stop
  wire rd_drive  = (state == redriver_cfg_pkg::ST_RDATA) && !tx[7];

  assign o_sda    = 1'b0;
  assign o_sda_oe = ack_state | rd_drive;

  // Register file, all zero at reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      general     <= redriver_cfg_pkg::RST_GENERAL;
      lane_enable <= redriver_cfg_pkg::RST_LANE_ENABLE;
      lane0_ctrl  <= redriver_cfg_pkg::RST_LANE0_CTRL;
      lane0_stage <= redriver_cfg_pkg::RST_LANE0_STAGE;
    end
    else
    begin
      if (wr_general)
        general <= shreg;
      if (wr_lane_en)
        lane_enable <= shreg[redriver_cfg_pkg::LANE_EN_W-1:0];
      if (wr_ctrl)
        lane0_ctrl <= shreg;
      if (wr_stage)
        lane0_stage <= shreg[redriver_cfg_pkg::STAGE_W-1:0];
    end
  end

  // Tracking selection
  logic [7:0] eff_ctrl;
  logic [2:0] eff_stage;
  logic [3:0] follow_lane1;
  logic       lane3_follow_lane2;

  lane_track_select u_track (
    .i_track_01_n         (general[redriver_cfg_pkg::GEN_TRACK_01]),
    .i_track_23_n         (general[redriver_cfg_pkg::GEN_TRACK_23]),
    .i_track_all_n        (general[redriver_cfg_pkg::GEN_TRACK_ALL]),
    .i_lane0_ctrl         (lane0_ctrl),
    .i_lane0_stage        (lane0_stage),
    .i_lane1_ctrl         (i_lane1_ctrl),
    .i_lane1_stage        (i_lane1_stage),
    .o_follow_lane1       (follow_lane1),
    .o_lane3_follow_lane2 (lane3_follow_lane2),
    .o_eff_ctrl           (eff_ctrl),
    .o_eff_stage          (eff_stage)
  );

  // Registered outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pin_control_active       <= 1'b0;
      o_power_off_request        <= 1'b0;
      o_equalizer_profile_select <= 1'b0;
      o_lane_disable             <= 4'h0;
      o_follow_lane1             <= 4'h0;
      o_lane3_follow_lane2       <= 1'b0;
      o_eq_strength_code         <= 3'h0;
      o_output_dc_gain_6db       <= 1'b0;
      o_input_dc_attenuation     <= 1'b0;
      o_rx_gain_code             <= 2'h0;
      o_driver_hf_boost          <= 1'b0;
      o_eq_stage_off             <= 1'b0;
      o_driver_stage_off_lane0   <= 1'b0;
    end
    else
    begin
      // Bus stays usable under pin control so software can hand control back
      o_pin_control_active <= general[redriver_cfg_pkg::GEN_CTRL_SRC] | ~mode_pin_s;
      o_power_off_request  <= general[redriver_cfg_pkg::GEN_POWER_OFF];
      o_equalizer_profile_select <= general[redriver_cfg_pkg::GEN_EQ_PROF];
      o_lane_disable       <= lane_enable;
      o_follow_lane1       <= follow_lane1;
      o_lane3_follow_lane2 <= lane3_follow_lane2;
      o_eq_strength_code   <= eff_ctrl[redriver_cfg_pkg::CTL_EQ_HI:redriver_cfg_pkg::CTL_EQ_LO];
      o_output_dc_gain_6db <= eff_ctrl[redriver_cfg_pkg::CTL_OUT_GAIN];
      o_input_dc_attenuation <= ~eff_ctrl[redriver_cfg_pkg::CTL_IN_GAIN];
      o_rx_gain_code       <= eff_ctrl[redriver_cfg_pkg::CTL_RX_HI:redriver_cfg_pkg::CTL_RX_LO];
      o_driver_hf_boost    <= eff_stage[redriver_cfg_pkg::STG_HF_BOOST];
      o_eq_stage_off       <= eff_stage[redriver_cfg_pkg::STG_EQ_OFF];
      o_driver_stage_off_lane0 <= eff_stage[redriver_cfg_pkg::STG_DRV_OFF];
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_reset_zero: assert property (
    $past(i_rst) |-> (general == 8'h00 && lane_enable == 4'h0 &&
                      lane0_ctrl == 8'h00 && lane0_stage == 3'h0))
    else $error("registers not zero after reset");

  chk_power_down: assert property (
    wr_general |-> ##2 (o_power_off_request == $past(shreg[6], 2)))
    else $error("power off output does not follow write");

  chk_profile_sel: assert property (
    wr_general |-> ##2 (o_equalizer_profile_select == $past(shreg[2], 2)))
    else $error("profile output does not follow write");

  chk_lane_disable: assert property (
    wr_lane_en |-> ##2 (o_lane_disable == $past(shreg[3:0], 2)))
    else $error("lane disable does not follow write");

  chk_upper_zero: assert property (
    (scl_fall && state == redriver_cfg_pkg::ST_ADDR_ACK && rd_dir &&
     index == redriver_cfg_pkg::IDX_LANE_ENABLE) |=> (tx[7:4] == 4'h0))
    else $error("unimplemented bits read nonzero");

  chk_read_hold: assert property (
    (state == redriver_cfg_pkg::ST_RDATA && scl_rise) |=> $stable(o_sda_oe))
    else $error("read data changed while clock high");

  chk_addr_nack: assert property (
    (state == redriver_cfg_pkg::ST_ADDR && scl_fall && byte_done && !addr_match &&
     !bus_start && !bus_stop) |=> (state == redriver_cfg_pkg::ST_IDLE && !o_sda_oe))
    else $error("foreign address acknowledged");

  chk_ack_drive: assert property (
    (state == redriver_cfg_pkg::ST_INDEX && scl_fall && byte_done && !bus_start &&
     !bus_stop) |=> o_sda_oe && (index == $past(shreg)))
    else $error("index byte not taken and acknowledged");

  chk_pin_ctrl: assert property (
    (!mode_pin_s || general[7]) |=> o_pin_control_active)
    else $error("pin control not selected");

  chk_track_prio: assert property (
    !general[3] |=> (!o_lane3_follow_lane2 && o_follow_lane1 == 4'hd))
    else $error("pairwise tracking overrides global tracking");

  chk_eq_code: assert property (
    (wr_ctrl && general[5] && general[3]) |-> ##2
      (o_eq_strength_code == $past(shreg[6:4], 2)))
    else $error("equalizer code does not follow write");

  chk_stage_off: assert property (
    (general[5] && general[3]) |=> (o_eq_stage_off == $past(lane0_stage[1])))
    else $error("equalizer stage off mismatch");

endmodule

`default_nettype wire

// ==== test/bus_master_model.sv ====
// Purpose: Two-wire bus master driving register writes and reads.
// Assumes: Open-drain data wire with pull-up; clock period 16 system clocks.
// Notes:   Clock rests high between frames; data is only ever pulled low.

`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  // Clock
  input  wire logic i_clk,
  // Bus wires
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial
  begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Long low phase so the target's acknowledge is gone before the next rise
  task automatic start_cond();
    o_sda_low = 1'b0;
    tick(8);
    o_scl = 1'b1;
    tick(8);
    o_sda_low = 1'b1;
    tick(8);
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic stop_cond();
    o_sda_low = 1'b1;
    tick(8);
    o_scl = 1'b1;
    tick(8);
    o_sda_low = 1'b0;
    tick(8);
  endtask

  task automatic xfer_bit(input logic b, output logic r);
    o_sda_low = ~b;
    tick(8);
    o_scl = 1'b1;
    tick(3);
    r = i_sda;
    tick(3);
    o_scl = 1'b0;
    tick(2);
  endtask

  // Ninth bit carries last: 1 releases for the target ack, 0 acks a read byte
  task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] r,
                           output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(d[i], s);
      r[i] = s;
    end
    xfer_bit(last, s);
    acked = ~s;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                           output logic ok);
    logic [7:0] r;
    logic       k1;
    logic       k2;
    logic       k3;
    start_cond();
    xfer_byte({a, 1'b0}, 1'b1, r, k1);
    xfer_byte(idx, 1'b1, r, k2);
    xfer_byte(d, 1'b1, r, k3);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
                          output logic ok);
    logic [7:0] r;
    logic       k1;
    logic       k2;
    logic       k3;
    start_cond();
    xfer_byte({a, 1'b0}, 1'b1, r, k1);
    xfer_byte(idx, 1'b1, r, k2);
    start_cond();
    xfer_byte({a, 1'b1}, 1'b1, r, k3);
    xfer_byte(8'hff, 1'b1, d, r[0]);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask
endmodule

`default_nettype wire

// ==== test/test_redriver_cfg_regs.sv ====
// Purpose: Self-checking bench for the redriver configuration registers.
// Assumes: Lane 1 copy held steady by the bench; receive gain 10 never written.
// Notes:   Expected outputs come from a shadow of the written registers.

`timescale 1ns/1ps
`default_nettype none

module test_redriver_cfg_regs;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_t;

  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [2:0] addr_pins = 3'h0;
  logic       mode_pin = 1'b1;
  logic [7:0] lane1_ctrl = 8'h3d;
  logic [2:0] lane1_stage = 3'h5;
  logic       scl, m_low, sda_out, sda_oe, pin_ctl, pwr, prof, l3f2, outg, inatt, boost;
  logic       eqoff, drvoff;
  logic [3:0] dis, follow;
  logic [2:0] eq;
  logic [1:0] rx;
  logic [7:0] gen = 8'h00, ctl = 8'h00, rd;
  logic [3:0] len = 4'h0;
  logic [2:0] stg = 3'h0;
  logic       ok;
  int         errors = 0, compares = 0, cycles = 0;
  // Released wire floats high through the pull-up
  wire logic  sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
  wire logic [21:0] out_vec = {pin_ctl, pwr, prof, dis, follow, l3f2, eq, outg, inatt, rx,
                               boost, eqoff, drvoff};
  // Reserved bits written as zero except the ff writes to indexes 01 and 03 and the a5 write to unmapped index 04, receive gain 10 avoided
  row_t rows [14] = '{'{8'h00, 8'h28, 8'h28}, '{8'h02, 8'h7f, 8'h7f},
                      '{8'h02, 8'h45, 8'h45}, '{8'h02, 8'h00, 8'h00},
                      '{8'h03, 8'hff, 8'h07}, '{8'h03, 8'h02, 8'h02},
                      '{8'h01, 8'hff, 8'h0f}, '{8'h01, 8'h05, 8'h05},
                      '{8'h00, 8'h38, 8'h38}, '{8'h00, 8'h30, 8'h30},
                      '{8'h00, 8'h08, 8'h08}, '{8'h00, 8'he4, 8'he4},
                      '{8'h04, 8'ha5, 8'h00}, '{8'h00, 8'h2c, 8'h2c}};

  always #2 i_clk = ~i_clk;

  redriver_cfg_regs redriver_cfg_regs_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_out),
    .o_sda_oe(sda_oe), .i_addr_pins(addr_pins), .i_ctrl_mode_pin(mode_pin),
    .i_lane1_ctrl(lane1_ctrl), .i_lane1_stage(lane1_stage), .o_pin_control_active(pin_ctl),
    .o_power_off_request(pwr), .o_equalizer_profile_select(prof), .o_lane_disable(dis),
    .o_follow_lane1(follow), .o_lane3_follow_lane2(l3f2), .o_eq_strength_code(eq),
    .o_output_dc_gain_6db(outg), .o_input_dc_attenuation(inatt), .o_rx_gain_code(rx),
    .o_driver_hf_boost(boost), .o_eq_stage_off(eqoff), .o_driver_stage_off_lane0(drvoff)
  );

  bus_master_model bus_master_model_inst (
    .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low)
  );

  function automatic logic [21:0] exp_vec();
    logic       t0;
    logic [7:0] c;
    logic [2:0] s;
    t0 = ~gen[3] | ~gen[5];
    c  = t0 ? lane1_ctrl : ctl;
    s  = t0 ? lane1_stage : stg;
    return {gen[7] | ~mode_pin, gen[6], gen[2], len, ~gen[3], ~gen[3], 1'b0, t0,
            gen[3] & ~gen[4], c[6:4], c[3], ~c[2], c[1:0], s};
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d);
    bus_master_model_inst.write_reg(a, idx, d, ok);
    case (idx)
      8'h00: gen = d;
      8'h01: len = d[3:0];
      8'h02: ctl = d;
      8'h03: stg = d[2:0];
      default: ;
    endcase
  endtask

  // Cuts a hang short; a full run needs roughly 20500 cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    check("reset outputs", exp_vec(), out_vec);
    for (int k = 0; k < 14; k++)
    begin
      wr(7'h00, rows[k].idx, rows[k].wdata);
      check("write ack", 1, ok);
      bus_master_model_inst.read_reg(7'h00, rows[k].idx, rd, ok);
      check("read data", rows[k].rdata, rd);
      check("read ack", 1, ok);
      check("outputs", exp_vec(), out_vec);
    end
    bus_master_model_inst.write_reg(7'h01, 8'h00, 8'h40, ok);
    check("foreign address ack", 0, ok);
    check("foreign address outputs", exp_vec(), out_vec);
    addr_pins = 3'h5;
    wr(7'h05, 8'h01, 8'h03);
    check("strapped address ack", 1, ok);
    check("strapped outputs", exp_vec(), out_vec);
    bus_master_model_inst.write_reg(7'h00, 8'h01, 8'h00, ok);
    check("old address ack", 0, ok);
    bus_master_model_inst.write_reg(7'h45, 8'h01, 8'h00, ok);
    check("upper address ack", 0, ok);
    mode_pin = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    check("pin control", exp_vec(), out_vec);
    addr_pins = 3'h0;
    mode_pin  = 1'b1;
    i_rst     = 1'b1;
    gen = 8'h00;
    ctl = 8'h00;
    len = 4'h0;
    stg = 3'h0;
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    check("second reset outputs", exp_vec(), out_vec);
    for (int k = 0; k < 4; k++)
    begin
      bus_master_model_inst.read_reg(7'h00, k[7:0], rd, ok);
      check("reset read", 8'h00, rd);
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
